// >>> inc/mft_pkg.sv
// package: register map, field layout and constants of the address filter and tally block
package mft_pkg;
    // ==========================================================
    // register byte addresses (word aligned, data in low byte)
    localparam logic [7:0] OFS_RSTART_LO = 8'h00;
    localparam logic [7:0] OFS_RSTART_HI = 8'h04;
    localparam logic [7:0] OFS_RCOUNT_LO = 8'h08;
    localparam logic [7:0] OFS_RCOUNT_HI = 8'h0C;
    localparam logic [7:0] OFS_RADDR_LO = 8'h10;
    localparam logic [7:0] OFS_RADDR_HI = 8'h14;
    localparam logic [7:0] OFS_RCTRL = 8'h18;
    localparam logic [7:0] OFS_MODE = 8'h1C;
    localparam logic [7:0] OFS_STATION0 = 8'h20;
    localparam logic [7:0] OFS_HASH0 = 8'h40;
    localparam logic [7:0] OFS_ALIGN_TALLY = 8'h60;
    localparam logic [7:0] OFS_CRC_TALLY = 8'h64;
    localparam logic [7:0] OFS_LOST_TALLY = 8'h68;
    localparam logic [7:0] OFS_PEEK = 8'h6C;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h70;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h74;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h78;
    // ==========================================================
    // fields
    localparam int RCTRL_START_BIT = 0;
    localparam int RCTRL_WORD_BIT = 1;
    localparam int MODE_MONITOR_BIT = 0;
    localparam int MODE_LOOP_LO_BIT = 1;
    localparam int MODE_LOOP_HI_BIT = 2;
    localparam int IRQ_RDONE_BIT = 0;
    localparam int IRQ_TALLY_BIT = 1;
    localparam int IRQ_WIDTH = 2;
    // ==========================================================
    // values
    localparam logic [7:0] TALLY_MAX = 8'hC0;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
    localparam int DA_BITS = 48;
    localparam int PEEK_DEPTH = 8;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    typedef enum logic [1:0] {MFT_IDLE, MFT_XFER} mft_rstate_t;
endpackage

// >>> inc/mft_tally_if.sv
// interface: event and clear lines between top and one tally counter
interface mft_tally_if;
    logic bump;
    logic clear;
    logic [7:0] value;
    logic at_max;
    modport owner (output bump, output clear, input value, input at_max);
    modport counter (input bump, input clear, output value, output at_max);
endinterface

// >>> src/mft_tally.sv
// saturating clear-on-read tally counter
module mft_tally
    import mft_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // control
    mft_tally_if.counter tif
);
    logic [7:0] cnt_r;
    // ==========================================================
    // counter
    // a bump in the clearing cycle is kept as a count of one so no event is lost
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cnt_r <= RESET_BYTE;
        end else if (tif.clear) begin
            cnt_r <= tif.bump ? 8'h01 : RESET_BYTE;
        end else if (tif.bump && cnt_r != TALLY_MAX) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
    assign tif.value = cnt_r;
    assign tif.at_max = (cnt_r == TALLY_MAX);
    a_tally_saturates: assert property (@(posedge CLK) disable iff (!RST_N)
        (cnt_r == TALLY_MAX && !tif.clear) |=> cnt_r == TALLY_MAX)
        else $error("tally moved past its ceiling");
    a_tally_clears: assert property (@(posedge CLK) disable iff (!RST_N)
        (tif.clear && !tif.bump) |=> cnt_r == 8'h00)
        else $error("tally not cleared by read");
endmodule

// >>> src/mft_top.sv
// top: remote dma pointers, station and hash filters, tallies and loopback peek over apb
//
// The register offsets and the APB slave port were chosen for this implementation.
module mft_top
    import mft_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // receive path
    input wire logic RX_BIT_VALID,
    input wire logic RX_BIT,
    input wire logic RX_FRAME_START,
    input wire logic RX_FRAME_END,
    input wire logic RX_CRC_ERR,
    input wire logic RX_ALIGN_ERR,
    input wire logic RX_NO_BUFFER,
    // remote dma data mover
    input wire logic RDMA_STEP,
    output logic RDMA_ACTIVE,
    output logic RDMA_WORD,
    output logic [15:0] RDMA_ADDR,
    // loopback transmit bytes
    input wire logic TX_BYTE_VALID,
    input wire logic [7:0] TX_BYTE,
    // filter result and interrupt
    output logic ADDR_MATCH,
    output logic ADDR_MATCH_VALID,
    output logic IRQ
);
    // ==========================================================
    // registers
    logic [15:0] rstart_r, rcount_r, raddr_r;
    logic rword_r, monitor_r;
    logic [1:0] loop_r;
    logic [7:0] station_r [6];
    logic [7:0] hash_r [8];
    logic [7:0] peek_r [PEEK_DEPTH];
    logic [2:0] peek_wr_r, peek_rd_r;
    logic [IRQ_WIDTH-1:0] irq_stat_r, irq_en_r;
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r;
    mft_rstate_t rstate_r;
    logic [31:0] crc_r;
    logic [47:0] da_r;
    logic [5:0] bitcnt_r;
    logic [5:0] hash_idx_r;
    logic da_done_r, match_r, match_valid_r;
    // ==========================================================
    // apb decode
    logic acc, wr, rd, mapped;
    logic [7:0] wbyte;
    assign acc = PSEL && PENABLE && !pready_r;
    // writes land on the completing edge, when the master sees pready high
    assign wr = PSEL && PENABLE && PWRITE && pready_r;
    assign rd = acc && !PWRITE;
    assign wbyte = PWDATA[7:0];
    always_comb begin
        mapped = 1'b0;
        if (PADDR <= OFS_IRQ_CLEAR && PADDR[1:0] == 2'b00) begin
            mapped = (PADDR < (OFS_STATION0 + 8'h18)) || (PADDR >= OFS_HASH0);
        end
    end
    // ==========================================================
    // remote dma
    logic rstart_cmd, rstep_ok;
    logic [15:0] rdelta;
    assign rstart_cmd = wr && PADDR == OFS_RCTRL && wbyte[RCTRL_START_BIT];
    assign rstep_ok = (rstate_r == MFT_XFER) && RDMA_STEP;
    assign rdelta = rword_r ? 16'h0002 : 16'h0001;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rstart_r <= RESET_WORD;
            rcount_r <= RESET_WORD;
            raddr_r <= RESET_WORD;
            rword_r <= 1'b0;
            rstate_r <= MFT_IDLE;
        end else begin
            case (rstate_r)
                MFT_IDLE: begin
                    if (wr && PADDR == OFS_RSTART_LO) rstart_r[7:0] <= wbyte;
                    if (wr && PADDR == OFS_RSTART_HI) rstart_r[15:8] <= wbyte;
                    if (wr && PADDR == OFS_RCOUNT_LO) rcount_r[7:0] <= wbyte;
                    if (wr && PADDR == OFS_RCOUNT_HI) rcount_r[15:8] <= wbyte;
                    if (rstart_cmd) begin
                        rword_r <= wbyte[RCTRL_WORD_BIT];
                        raddr_r <= rstart_r;
                        if (rcount_r != RESET_WORD) rstate_r <= MFT_XFER;
                    end
                end
                MFT_XFER: begin
                    if (rstep_ok) begin
                        raddr_r <= raddr_r + rdelta;
                        // a word step on an odd remainder just empties the count
                        if (rcount_r <= rdelta) begin
                            rcount_r <= RESET_WORD;
                            rstate_r <= MFT_IDLE;
                        end else begin
                            rcount_r <= rcount_r - rdelta;
                        end
                    end
                end
                default: rstate_r <= MFT_IDLE;
            endcase
        end
    end
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            RDMA_ACTIVE <= 1'b0;
            RDMA_WORD <= 1'b0;
            RDMA_ADDR <= RESET_WORD;
        end else begin
            RDMA_ACTIVE <= (rstate_r == MFT_XFER) && !(rstep_ok && rcount_r <= rdelta);
            RDMA_WORD <= rword_r;
            RDMA_ADDR <= rstep_ok ? raddr_r + rdelta : raddr_r;
        end
    end
    a_rdma_step: assert property (@(posedge CLK) disable iff (!RST_N)
        rstep_ok |=> raddr_r == $past(raddr_r) + (rword_r ? 16'h0002 : 16'h0001))
        else $error("remote address stepped wrongly");
    a_rdma_end: assert property (@(posedge CLK) disable iff (!RST_N)
        (rstep_ok && rcount_r <= rdelta) |=> rstate_r == MFT_IDLE && rcount_r == 16'h0000)
        else $error("remote transfer did not end at zero");
    a_rdma_count: assert property (@(posedge CLK) disable iff (!RST_N)
        (rstep_ok && rcount_r > rdelta) |=> rcount_r == $past(rcount_r) - $past(rdelta))
        else $error("remote count stepped wrongly");
    // ==========================================================
    // control, station address and hash filter registers
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            monitor_r <= 1'b0;
            loop_r <= 2'b00;
            for (int i = 0; i < 6; i++) station_r[i] <= RESET_BYTE;
            for (int i = 0; i < 8; i++) hash_r[i] <= RESET_BYTE;
        end else if (wr) begin
            if (PADDR == OFS_MODE) begin
                monitor_r <= wbyte[MODE_MONITOR_BIT];
                loop_r <= wbyte[MODE_LOOP_HI_BIT:MODE_LOOP_LO_BIT];
            end
            for (int i = 0; i < 6; i++) begin
                if (PADDR == OFS_STATION0 + 8'(4 * i)) station_r[i] <= wbyte;
            end
            for (int i = 0; i < 8; i++) begin
                if (PADDR == OFS_HASH0 + 8'(4 * i)) hash_r[i] <= wbyte;
            end
        end
    end
    // ==========================================================
    // receive address filter: bit serial, least significant bit first
    logic crc_fb;
    logic [47:0] da_full;
    logic [5:0] hidx;
    logic station_hit, hash_hit;
    assign crc_fb = crc_r[31] ^ RX_BIT;
    assign da_full = {RX_BIT, da_r[47:1]};
    always_ff @(posedge CLK) begin
        if (!RST_N || RX_FRAME_START) begin
            crc_r <= CRC_INIT;
            da_r <= 48'h000000000000;
            bitcnt_r <= 6'h00;
            da_done_r <= 1'b0;
            hash_idx_r <= 6'h00;
        end else if (RX_BIT_VALID && !da_done_r) begin
            crc_r <= {crc_r[30:0], 1'b0} ^ (crc_fb ? CRC_POLY : 32'h00000000);
            da_r <= da_full;
            bitcnt_r <= bitcnt_r + 6'h01;
            if (bitcnt_r == 6'(DA_BITS - 1)) begin
                da_done_r <= 1'b1;
                hash_idx_r <= crc_r[30:25] ^ (crc_fb ? CRC_POLY[31:26] : 6'h00);
            end
        end
    end
    assign hidx = hash_idx_r;
    always_comb begin
        station_hit = 1'b1;
        for (int i = 0; i < 6; i++) begin
            if (da_r[8*i +: 8] != station_r[i]) station_hit = 1'b0;
        end
        hash_hit = hash_r[hidx[5:3]][hidx[2:0]];
    end
    logic da_evt;
    assign da_evt = RX_BIT_VALID && !da_done_r && bitcnt_r == 6'(DA_BITS - 1) && !RX_FRAME_START && RST_N;
    // the match is judged the cycle after the last address bit is shifted in
    logic judge_r;
    always_ff @(posedge CLK) begin
        if (!RST_N || RX_FRAME_START) begin
            judge_r <= 1'b0;
            match_r <= 1'b0;
            match_valid_r <= 1'b0;
        end else begin
            judge_r <= da_evt;
            if (judge_r) begin
                match_valid_r <= 1'b1;
                match_r <= da_r[0] ? hash_hit : station_hit;
            end
        end
    end
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ADDR_MATCH <= 1'b0;
            ADDR_MATCH_VALID <= 1'b0;
        end else begin
            ADDR_MATCH <= match_r;
            ADDR_MATCH_VALID <= match_valid_r;
        end
    end
    a_match_hash: assert property (@(posedge CLK) disable iff (!RST_N)
        (judge_r && !RX_FRAME_START && da_r[0]) |=> match_r == $past(hash_hit))
        else $error("multicast decision ignores filter bit");
    a_match_station: assert property (@(posedge CLK) disable iff (!RST_N)
        (judge_r && !RX_FRAME_START && !da_r[0]) |=> match_r == $past(station_hit))
        else $error("physical decision ignores station address");
    // ==========================================================
    // tallies
    mft_tally_if align_if ();
    mft_tally_if crc_if ();
    mft_tally_if lost_if ();
    logic recog_end;
    assign recog_end = RX_FRAME_END && match_valid_r && match_r;
    assign align_if.bump = recog_end && RX_ALIGN_ERR;
    assign crc_if.bump = recog_end && RX_CRC_ERR && !RX_ALIGN_ERR;
    assign lost_if.bump = monitor_r ? recog_end : (RX_FRAME_END && RX_NO_BUFFER);
    assign align_if.clear = rd && PADDR == OFS_ALIGN_TALLY;
    assign crc_if.clear = rd && PADDR == OFS_CRC_TALLY;
    assign lost_if.clear = rd && PADDR == OFS_LOST_TALLY;
    mft_tally u_align (.CLK(CLK), .RST_N(RST_N), .tif(align_if));
    mft_tally u_crc (.CLK(CLK), .RST_N(RST_N), .tif(crc_if));
    mft_tally u_lost (.CLK(CLK), .RST_N(RST_N), .tif(lost_if));
    a_lost_monitor: assert property (@(posedge CLK) disable iff (!RST_N)
        (monitor_r && recog_end && !lost_if.clear && !lost_if.at_max)
        |=> lost_if.value == $past(lost_if.value) + 8'h01)
        else $error("monitor mode match not counted");
    // ==========================================================
    // loopback peek ring: keeps the last eight transmitted bytes
    logic peek_rd;
    assign peek_rd = rd && PADDR == OFS_PEEK && loop_r != 2'b00;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            peek_wr_r <= 3'h0;
            peek_rd_r <= 3'h0;
            for (int i = 0; i < PEEK_DEPTH; i++) peek_r[i] <= RESET_BYTE;
        end else begin
            if (TX_BYTE_VALID && loop_r != 2'b00) begin
                peek_r[peek_wr_r] <= TX_BYTE;
                peek_wr_r <= peek_wr_r + 3'h1;
                peek_rd_r <= peek_wr_r + 3'h1;
            end else if (peek_rd) begin
                peek_rd_r <= peek_rd_r + 3'h1;
            end
        end
    end
    // ==========================================================
    // interrupts: set wins over clear
    logic [IRQ_WIDTH-1:0] irq_set, irq_clr;
    assign irq_set[IRQ_RDONE_BIT] = rstep_ok && rcount_r <= rdelta;
    assign irq_set[IRQ_TALLY_BIT] = (align_if.bump || crc_if.bump || lost_if.bump);
    assign irq_clr = (wr && PADDR == OFS_IRQ_CLEAR) ? wbyte[IRQ_WIDTH-1:0] : '0;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            irq_stat_r <= '0;
            irq_en_r <= '0;
            IRQ <= 1'b0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
            if (wr && PADDR == OFS_IRQ_ENABLE) irq_en_r <= wbyte[IRQ_WIDTH-1:0];
            IRQ <= |(irq_stat_r & irq_en_r);
        end
    end
    // ==========================================================
    // apb read and answer: one wait cycle, answer on the second access edge
    logic [7:0] rbyte;
    always_comb begin
        rbyte = RESET_BYTE;
        case (PADDR)
            OFS_RSTART_LO: rbyte = rstart_r[7:0];
            OFS_RSTART_HI: rbyte = rstart_r[15:8];
            OFS_RCOUNT_LO: rbyte = rcount_r[7:0];
            OFS_RCOUNT_HI: rbyte = rcount_r[15:8];
            OFS_RADDR_LO: rbyte = raddr_r[7:0];
            OFS_RADDR_HI: rbyte = raddr_r[15:8];
            OFS_RCTRL: rbyte = {6'h00, rword_r, rstate_r == MFT_XFER};
            OFS_MODE: rbyte = {5'h00, loop_r, monitor_r};
            OFS_ALIGN_TALLY: rbyte = align_if.value;
            OFS_CRC_TALLY: rbyte = crc_if.value;
            OFS_LOST_TALLY: rbyte = lost_if.value;
            OFS_PEEK: rbyte = peek_r[peek_rd_r];
            OFS_IRQ_STATUS: rbyte = {6'h00, irq_stat_r};
            OFS_IRQ_ENABLE: rbyte = {6'h00, irq_en_r};
            default: begin
                for (int i = 0; i < 6; i++) begin
                    if (PADDR == OFS_STATION0 + 8'(4 * i)) rbyte = station_r[i];
                end
                for (int i = 0; i < 8; i++) begin
                    if (PADDR == OFS_HASH0 + 8'(4 * i)) rbyte = hash_r[i];
                end
            end
        endcase
    end
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= acc;
            pslverr_r <= acc && !mapped;
            if (rd) prdata_r <= {24'h000000, rbyte};
        end
    end
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign PRDATA = prdata_r;
    a_apb_one_wait: assert property (@(posedge CLK) disable iff (!RST_N)
        (PSEL && PENABLE && !PREADY) |=> PREADY)
        else $error("apb answer not one cycle after access");
endmodule

// >>> testbench/mft_rx_model.sv
// partner model: receive bit source, remote dma mover and loopback byte source
module mft_rx_model (
    // clock
    input wire logic clk,
    // remote dma mover
    input wire logic rdma_active,
    output logic rdma_step,
    // receive path
    output logic rx_valid,
    output logic rx_bit,
    output logic rx_start,
    output logic rx_end,
    output logic rx_crc_err,
    output logic rx_align_err,
    output logic rx_no_buffer,
    // loopback transmit
    output logic tx_valid,
    output logic [7:0] tx_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    // =====
    // idle levels
    initial begin
        {rdma_step, rx_valid, rx_bit, rx_start, rx_end} = 5'h00;
        {rx_crc_err, rx_align_err, rx_no_buffer, tx_valid} = 4'h0;
        tx_byte = 8'h00;
    end
    // =====
    // mover steps every other cycle, so no step lands after the block goes idle
    always @(posedge clk) rdma_step <= rdma_active && !rdma_step;
    // =====
    // one frame: start pulse, 48 address bits lsb first, end pulse with error levels
    task automatic send_frame(input logic [47:0] da, input logic ce, input logic ae, input logic nb);
        @(posedge clk);
        rx_start <= 1'b1;
        @(posedge clk);
        rx_start <= 1'b0;
        for (int i = 0; i < 48; i++) begin
            rx_valid <= 1'b1;
            rx_bit <= da[i];
            @(posedge clk);
        end
        rx_valid <= 1'b0;
        // released data line shows the inverse, never a stale bit
        rx_bit <= ~da[47];
        repeat (5) @(posedge clk);
        rx_end <= 1'b1;
        {rx_crc_err, rx_align_err, rx_no_buffer} <= {ce, ae, nb};
        @(posedge clk);
        rx_end <= 1'b0;
        {rx_crc_err, rx_align_err, rx_no_buffer} <= ~{ce, ae, nb};
    endtask
    task automatic send_tx(input logic [7:0] b);
        @(posedge clk);
        tx_valid <= 1'b1;
        tx_byte <= b;
        @(posedge clk);
        tx_valid <= 1'b0;
        tx_byte <= ~b;
    endtask
endmodule

// >>> testbench/mft_top_tb.sv
// testbench: apb sequences against the filter, tally, remote dma and peek block
module mft_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mft_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr, tx_byte;
    logic [31:0] pwdata, prdata;
    logic rx_valid, rx_bit, rx_start, rx_end, rx_crc_err, rx_align_err, rx_no_buffer;
    logic rdma_step, rdma_active, rdma_word, tx_valid, addr_match, addr_match_valid;
    logic [15:0] rdma_addr;
    int n_errors = 0;
    int n_compared = 0;
    int n_cycles = 0;
    mft_top uut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .RX_BIT_VALID(rx_valid), .RX_BIT(rx_bit), .RX_FRAME_START(rx_start), .RX_FRAME_END(rx_end),
        .RX_CRC_ERR(rx_crc_err), .RX_ALIGN_ERR(rx_align_err), .RX_NO_BUFFER(rx_no_buffer),
        .RDMA_STEP(rdma_step), .RDMA_ACTIVE(rdma_active), .RDMA_WORD(rdma_word), .RDMA_ADDR(rdma_addr),
        .TX_BYTE_VALID(tx_valid), .TX_BYTE(tx_byte), .ADDR_MATCH(addr_match),
        .ADDR_MATCH_VALID(addr_match_valid), .IRQ(irq));
    mft_rx_model rx (.clk(clk), .rdma_active(rdma_active), .rdma_step(rdma_step), .rx_valid(rx_valid),
        .rx_bit(rx_bit), .rx_start(rx_start), .rx_end(rx_end), .rx_crc_err(rx_crc_err),
        .rx_align_err(rx_align_err), .rx_no_buffer(rx_no_buffer), .tx_valid(tx_valid), .tx_byte(tx_byte));
    // =====
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        n_cycles++;
        if (n_cycles == 60000) begin
            n_errors++;
            end_sim();
        end
    end
    // =====
    // checks and closing
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // =====
    // apb master: hold the request until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, wd};
        @(posedge clk);
        penable <= 1'b1;
        // no cycle count assumed: pready seen high or the bench timeout ends this wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable, pwdata} <= {1'b0, 1'b0, ~wd};
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {24'h000000, d}, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h00000000, r, e);
        chk(r, {24'h000000, exp});
    endtask
    task automatic frame(input logic [47:0] da, input logic [2:0] ern, input logic exp);
        rx.send_frame(da, ern[2], ern[1], ern[0]);
        chk_flag(addr_match_valid, 1'b1);
        chk_flag(addr_match, exp);
    endtask
    task automatic run_dma(input logic [15:0] st, input logic [15:0] cnt, input logic word);
        int n;
        logic [15:0] fin;
        fin = st + cnt;
        wr(OFS_RSTART_LO, st[7:0]);
        wr(OFS_RSTART_HI, st[15:8]);
        wr(OFS_RCOUNT_LO, cnt[7:0]);
        wr(OFS_RCOUNT_HI, cnt[15:8]);
        wr(OFS_RCTRL, {6'h00, word, 1'b1});
        n = 0;
        while (rdma_active !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        chk({16'h0000, rdma_addr}, {16'h0000, st});
        chk_flag(rdma_word, word);
        while (rdma_active === 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        chk({16'h0000, rdma_addr}, {16'h0000, fin});
        rd(OFS_RADDR_LO, fin[7:0]);
        rd(OFS_RADDR_HI, fin[15:8]);
        rd(OFS_RCOUNT_LO, 8'h00);
        rd(OFS_RCOUNT_HI, 8'h00);
    endtask
    // own crc so the hash bin is never read back from the design
    function automatic logic [5:0] hash6(input logic [47:0] da);
        logic [31:0] c;
        c = CRC_INIT;
        for (int i = 0; i < DA_BITS; i++)
            c = {c[30:0], 1'b0} ^ ((c[31] ^ da[i]) ? CRC_POLY : 32'h00000000);
        return c[31:26];
    endfunction
    // =====
    // main sequence
    initial begin
        logic [31:0] r;
        logic e;
        logic [5:0] h;
        logic [47:0] sa;
        logic [47:0] mc;
        {psel, penable, pwrite, paddr, pwdata} = 43'h0;
        rst_n = 1'b0;
        sa = 48'hA1B2C3D4E5F6;
        mc = 48'h01005E000001;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_ALIGN_TALLY, 8'h00);
        rd(OFS_HASH0, 8'h00);
        apb(1'b1, 8'h3C, 32'h000000FF, r, e);
        chk_flag(e, 1'b1);
        apb(1'b0, 8'h7C, 32'h00000000, r, e);
        chk_flag(e, 1'b1);
        chk(r, 32'h00000000);
        wr(OFS_IRQ_CLEAR, 8'h03);
        wr(OFS_IRQ_ENABLE, 8'h01);
        run_dma(16'h00FE, 16'h0005, 1'b0);
        run_dma(16'h0010, 16'h0104, 1'b1);
        repeat (2) @(posedge clk);
        chk_flag(irq, 1'b1);
        rd(OFS_IRQ_STATUS, 8'h01);
        wr(OFS_IRQ_ENABLE, 8'h00);
        repeat (2) @(posedge clk);
        chk_flag(irq, 1'b0);
        wr(OFS_IRQ_ENABLE, 8'h01);
        wr(OFS_IRQ_CLEAR, 8'h01);
        repeat (2) @(posedge clk);
        chk_flag(irq, 1'b0);
        for (int i = 0; i < 6; i++)
            wr(8'(OFS_STATION0 + 4 * i), sa[8 * i +: 8]);
        rd(8'(OFS_STATION0 + 20), sa[47:40]);
        frame(sa, 3'h4, 1'b1);
        frame(sa, 3'h6, 1'b1);
        frame(sa ^ 48'h010000000000, 3'h4, 1'b0);
        frame(sa ^ 48'h000000000002, 3'h1, 1'b0);
        rd(OFS_ALIGN_TALLY, 8'h01);
        rd(OFS_CRC_TALLY, 8'h01);
        rd(OFS_LOST_TALLY, 8'h01);
        rd(OFS_IRQ_STATUS, 8'h02);
        rd(OFS_ALIGN_TALLY, 8'h00);
        rd(OFS_CRC_TALLY, 8'h00);
        wr(OFS_MODE, 8'h01);
        rd(OFS_MODE, 8'h01);
        frame(sa, 3'h0, 1'b1);
        rd(OFS_LOST_TALLY, 8'h01);
        wr(OFS_MODE, 8'h00);
        h = hash6(mc);
        for (int i = 0; i < 8; i++)
            wr(8'(OFS_HASH0 + 4 * i), 8'hFF);
        frame(mc, 3'h0, 1'b1);
        wr(8'(OFS_HASH0 + 4 * h[5:3]), ~(8'h01 << h[2:0]));
        frame(mc, 3'h0, 1'b0);
        wr(8'(OFS_HASH0 + 4 * h[5:3]), 8'h01 << h[2:0]);
        frame(mc, 3'h0, 1'b1);
        rd(8'(OFS_HASH0 + 4 * h[5:3]), 8'h01 << h[2:0]);
        repeat (195) rx.send_frame(sa, 1'b1, 1'b0, 1'b0);
        rd(OFS_CRC_TALLY, TALLY_MAX);
        rd(OFS_CRC_TALLY, 8'h00);
        wr(OFS_MODE, 8'h02);
        for (int i = 0; i < 10; i++)
            rx.send_tx(8'(8'h10 + i));
        for (int i = 0; i < PEEK_DEPTH; i++)
            rd(OFS_PEEK, 8'(8'h12 + i));
        wr(OFS_MODE, 8'h00);
        end_sim();
    end
endmodule
